// ### hdl/tsr_recorder.sv
// Triggered four-channel signal recorder with live readout, APB slave
//
// How it works
// - Four channels, 250 samples each at most
// - Each channel enabled, signal source selectable
// - Period multiple of 4 ms, 4 ms to 60 s
// - First sample at trigger, then once per period
// - Trigger: source channel, edge, threshold level
// - Start arms; trigger captures and streams samples
// - Start appends after samples already stored
// - Stop halts capture and sending; start resumes
// - Clear discards samples, recorder empty again
// - Any configuration commit discards stored samples
// - Configuration kept in registers, samples not
// - Link off blocks recording, configuration editable
// - Actual and difference only in modes 4,7,9
// - Solenoid setpoints are pre-stage derated signals
// - Window reached and trailing error flags
// - Digital inputs and outputs read as 1/0
// - Readout refreshed continuously while on-line
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tsr_defines.svh"

module tsr_recorder #(
  parameter int TICK_CYC = `TSR_CLK_HZ / 1000 * `TSR_TICK_MS
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_reset,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [7:0]        i_paddr,
  input  wire tsr_pkg::tsr_word_t i_pwdata,
  output var  tsr_pkg::tsr_word_t o_prdata,
  output var  logic              o_pready,
  output var  logic              o_pslverr,
  output var  logic              o_irq,
  output var  logic              o_recording,
  input  wire logic              i_link_on,
  input  wire logic [127:0]      i_sig,
  input  wire logic [3:0]        i_ctrl_mode,
  input  wire tsr_pkg::tsr_smp_t i_act_val,
  input  wire tsr_pkg::tsr_smp_t i_ctrl_diff,
  input  wire tsr_pkg::tsr_smp_t i_sol_a_set,
  input  wire tsr_pkg::tsr_smp_t i_sol_b_set,
  input  wire logic              i_win_reached,
  input  wire logic              i_trail_err,
  input  wire logic [7:0]        i_din,
  input  wire logic [7:0]        i_dout
);
  import tsr_pkg::*;

  localparam logic [17:0] TICK_LAST = 18'(TICK_CYC - 1);
  localparam logic [13:0] PER_MAX   = 14'(`TSR_PER_MAX_MS / `TSR_TICK_MS);

  //////////////////////////////////////////////////////////////////////////////
  // State and sample memory
  tsr_regs_t r_reg;
  tsr_regs_t r_next;
  logic [63:0] mem [0:249];
  logic        cap_we;
  logic [63:0] cap_word;

  function automatic tsr_smp_t pick(input logic [2:0] s, input logic [127:0] v);
    pick = v[{s, 4'h0} +: 16];
  endfunction

  function automatic tsr_smp_t chan(input logic [1:0] c, input logic [11:0] s,
                                    input logic [127:0] v);
    chan = pick(s[{1'b0, c, 1'b0} + {2'b00, c} +: 3], v);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Sample word and trigger detection
  logic [63:0] live;
  tsr_smp_t    trig_cur;
  logic        trig_hit;
  logic        tick;
  logic        per_end;
  logic        tx_avail;

  genvar g;
  generate
    for (g = 0; g < `TSR_NUM_CH; g++) begin : g_ch
      assign live[g*16 +: 16] = r_reg.ch_en[g] ?
                                chan(2'(g), r_reg.sel, i_sig) : 16'h0000;
    end
  endgenerate

  assign trig_cur = chan(r_reg.trig_ch, r_reg.sel, i_sig);
  assign trig_hit = r_reg.trig_fall ?
                    (r_reg.trig_prev >= r_reg.lvl && trig_cur < r_reg.lvl) :
                    (r_reg.trig_prev < r_reg.lvl && trig_cur >= r_reg.lvl);
  assign tick     = r_reg.tick_cnt == TICK_LAST;
  assign per_end  = tick && (r_reg.per_cnt == r_reg.per - 14'h0001);
  assign tx_avail = (r_reg.st == TSR_RUN || r_reg.st == TSR_FULL) &&
                    r_reg.tx_ptr < r_reg.wr_ptr;

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  logic       wr_acc;
  logic       rd_acc;
  logic       commit;
  logic       cmd_start;
  logic       cmd_stop;
  logic       cmd_clear;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic [13:0] per_w;

  always_comb begin
    r_next    = r_reg;
    cap_we    = 1'b0;
    cap_word  = live;
    irq_set   = 3'h0;
    irq_clr   = 3'h0;
    wr_acc    = i_psel && i_penable && r_reg.pready && i_pwrite;
    rd_acc    = i_psel && i_penable && r_reg.pready && !i_pwrite;
    commit    = 1'b0;
    cmd_start = 1'b0;
    cmd_stop  = 1'b0;
    cmd_clear = 1'b0;
    per_w     = i_pwdata[13:0];

    r_next.trig_prev = trig_cur;
    r_next.tick_cnt  = tick ? 18'h00000 : r_reg.tick_cnt + 18'h00001;
    if (tick) begin
      r_next.per_cnt = per_end ? 14'h0000 : r_reg.per_cnt + 14'h0001;
    end

    // Register writes
    if (wr_acc) begin
      if (i_paddr == `TSR_A_CMD) begin
        cmd_start = i_pwdata[`TSR_CMD_START];
        cmd_stop  = i_pwdata[`TSR_CMD_STOP];
        cmd_clear = i_pwdata[`TSR_CMD_CLEAR];
      end else if (i_paddr == `TSR_A_CFG) begin
        r_next.ch_en     = i_pwdata[3:0];
        r_next.trig_ch   = i_pwdata[5:4];
        r_next.trig_fall = i_pwdata[6];
        commit           = 1'b1;
      end else if (i_paddr == `TSR_A_SEL) begin
        r_next.sel = i_pwdata[11:0];
        commit     = 1'b1;
      end else if (i_paddr == `TSR_A_PER) begin
        // Clamp on the whole word so large values do not wrap into range
        if (i_pwdata == 32'h00000000) begin
          r_next.per = 14'h0001;
        end else if (i_pwdata > {18'h00000, PER_MAX}) begin
          r_next.per = PER_MAX;
        end else begin
          r_next.per = per_w;
        end
        commit = 1'b1;
      end else if (i_paddr == `TSR_A_LVL) begin
        r_next.lvl = i_pwdata[15:0];
        commit     = 1'b1;
      end else if (i_paddr == `TSR_A_SCALE) begin
        r_next.scale = i_pwdata;
        commit       = 1'b1;
      end else if (i_paddr == `TSR_A_IRQ_ST) begin
        irq_clr = i_pwdata[2:0];
      end else if (i_paddr == `TSR_A_IRQ_MSK) begin
        r_next.irq_msk = i_pwdata[2:0];
      end
    end

    // Recorder sequence
    case (r_reg.st)
      TSR_IDLE: begin
        if (cmd_start && i_link_on) begin
          r_next.st = (r_reg.wr_ptr == `TSR_MAX_SMP) ? TSR_FULL : TSR_ARMED;
        end
      end
      TSR_ARMED: begin
        if (trig_hit) begin
          cap_we           = 1'b1;
          r_next.tick_cnt  = 18'h00000;
          r_next.per_cnt   = 14'h0000;
          irq_set[`TSR_IRQ_TRIG] = 1'b1;
          r_next.st        = TSR_RUN;
        end
      end
      TSR_RUN: begin
        if (per_end) begin
          cap_we = 1'b1;
        end
      end
      TSR_FULL: begin
        r_next.st = TSR_FULL;
      end
      default: r_next.st = TSR_IDLE;
    endcase

    if (cap_we) begin
      r_next.wr_ptr         = r_reg.wr_ptr + 8'h01;
      irq_set[`TSR_IRQ_SMP] = 1'b1;
      if (r_reg.wr_ptr == `TSR_MAX_SMP - 8'h01) begin
        r_next.st              = TSR_FULL;
        irq_set[`TSR_IRQ_FULL] = 1'b1;
      end
    end

    // Sample stream: reading the upper word takes the record
    if (rd_acc && i_paddr == `TSR_A_TX_HI && tx_avail) begin
      r_next.tx_ptr = r_reg.tx_ptr + 8'h01;
    end

    if (cmd_stop || !i_link_on) begin
      r_next.st = TSR_IDLE;
    end
    if (cmd_clear || commit) begin
      r_next.st     = TSR_IDLE;
      r_next.wr_ptr = 8'h00;
      r_next.tx_ptr = 8'h00;
      cap_we        = 1'b0;
      irq_set       = 3'h0;
    end

    // Live readout
    if (i_link_on) begin
      if (i_ctrl_mode == `TSR_MODE_A || i_ctrl_mode == `TSR_MODE_B ||
          i_ctrl_mode == `TSR_MODE_C) begin
        r_next.act = {i_ctrl_diff, i_act_val};
      end else begin
        r_next.act = 32'h00000000;
      end
      r_next.sol = {i_sol_b_set, i_sol_a_set};
      r_next.io  = {i_dout, i_din, i_trail_err, i_win_reached};
    end

    // Interrupts: set wins over write-one-to-clear
    r_next.irq_st = (r_reg.irq_st & ~irq_clr) | irq_set;
    r_next.irq    = |(r_next.irq_st & r_next.irq_msk);
    r_next.rec    = r_next.st == TSR_RUN;

    // APB answer one cycle after setup
    r_next.pready  = i_psel && !i_penable;
    r_next.pslverr = 1'b0;
    r_next.prdata  = 32'h00000000;
    if (i_psel && !i_penable) begin
      if (i_paddr == `TSR_A_CMD) begin
        r_next.prdata = 32'h00000000;
      end else if (i_paddr == `TSR_A_CFG) begin
        r_next.prdata = {25'h0, r_reg.trig_fall, r_reg.trig_ch, r_reg.ch_en};
      end else if (i_paddr == `TSR_A_SEL) begin
        r_next.prdata = {20'h00000, r_reg.sel};
      end else if (i_paddr == `TSR_A_PER) begin
        r_next.prdata = {18'h00000, r_reg.per};
      end else if (i_paddr == `TSR_A_LVL) begin
        r_next.prdata = {16'h0000, r_reg.lvl};
      end else if (i_paddr == `TSR_A_SCALE) begin
        r_next.prdata = r_reg.scale;
      end else if (i_paddr == `TSR_A_STAT) begin
        r_next.prdata = {8'h00, r_reg.tx_ptr, r_reg.wr_ptr, 5'h00, tx_avail, r_reg.st};
      end else if (i_paddr == `TSR_A_IRQ_ST) begin
        r_next.prdata = {29'h0, r_reg.irq_st};
      end else if (i_paddr == `TSR_A_IRQ_MSK) begin
        r_next.prdata = {29'h0, r_reg.irq_msk};
      end else if (i_paddr == `TSR_A_TX_LO) begin
        r_next.prdata = tx_avail ? mem[r_reg.tx_ptr][31:0] : 32'h00000000;
      end else if (i_paddr == `TSR_A_TX_HI) begin
        r_next.prdata = tx_avail ? mem[r_reg.tx_ptr][63:32] : 32'h00000000;
      end else if (i_paddr == `TSR_A_ACT) begin
        r_next.prdata = r_reg.act;
      end else if (i_paddr == `TSR_A_SOL) begin
        r_next.prdata = r_reg.sol;
      end else if (i_paddr == `TSR_A_IO) begin
        r_next.prdata = {14'h0000, r_reg.io};
      end else begin
        r_next.pslverr = 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      r_reg     <= '0;
      r_reg.st  <= TSR_IDLE;
      r_reg.per <= `TSR_PER_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (cap_we) begin
      mem[r_reg.wr_ptr] <= cap_word;
    end
  end

  assign o_prdata    = r_reg.prdata;
  assign o_pready    = r_reg.pready;
  assign o_pslverr   = r_reg.pslverr;
  assign o_irq       = r_reg.irq;
  assign o_recording = r_reg.rec;

endmodule

`default_nettype wire

// ### hdl/tsr_defines.svh
// Offsets, fields, reset values and timing counts of the signal recorder
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH
`define TSR_CLK_HZ     40000000
`define TSR_TICK_MS    4
`define TSR_PER_MAX_MS 60000
`define TSR_MAX_SMP    8'd250
`define TSR_NUM_CH     4
`define TSR_NUM_SIG    8
`define TSR_A_CMD      8'h00
`define TSR_A_CFG      8'h04
`define TSR_A_SEL      8'h08
`define TSR_A_PER      8'h0c
`define TSR_A_LVL      8'h10
`define TSR_A_SCALE    8'h14
`define TSR_A_STAT     8'h18
`define TSR_A_IRQ_ST   8'h1c
`define TSR_A_IRQ_MSK  8'h20
`define TSR_A_TX_LO    8'h24
`define TSR_A_TX_HI    8'h28
`define TSR_A_ACT      8'h2c
`define TSR_A_SOL      8'h30
`define TSR_A_IO       8'h34
`define TSR_CMD_START  0
`define TSR_CMD_STOP   1
`define TSR_CMD_CLEAR  2
`define TSR_IRQ_TRIG   0
`define TSR_IRQ_FULL   1
`define TSR_IRQ_SMP    2
`define TSR_PER_RST    14'h0001
`define TSR_MODE_A     4'h4
`define TSR_MODE_B     4'h7
`define TSR_MODE_C     4'h9
`endif

// ### hdl/tsr_pkg.sv
// Types of the triggered signal recorder
package tsr_pkg;
  typedef logic [31:0] tsr_word_t;
  typedef logic [15:0] tsr_smp_t;

  typedef enum logic [1:0] {
    TSR_IDLE  = 2'b00,
    TSR_ARMED = 2'b01,
    TSR_RUN   = 2'b10,
    TSR_FULL  = 2'b11
  } tsr_state_t;

  typedef struct packed {
    tsr_state_t  st;
    logic [17:0] tick_cnt;
    logic [13:0] per_cnt;
    logic [7:0]  wr_ptr;
    logic [7:0]  tx_ptr;
    logic [3:0]  ch_en;
    logic [11:0] sel;
    logic [1:0]  trig_ch;
    logic        trig_fall;
    logic [13:0] per;
    tsr_smp_t    lvl;
    logic [31:0] scale;
    tsr_smp_t    trig_prev;
    logic [31:0] act;
    logic [31:0] sol;
    logic [17:0] io;
    logic [2:0]  irq_st;
    logic [2:0]  irq_msk;
    tsr_word_t   prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        rec;
  } tsr_regs_t;
endpackage

// ### test/tsr_host.sv
// Host model: APB master that configures and reads the recorder
`timescale 1ns/1ps
`default_nettype none
module tsr_host (
  input  wire logic               i_clk,
  input  wire logic               i_pready,
  input  wire logic               i_pslverr,
  input  wire tsr_pkg::tsr_word_t i_prdata,
  output var  logic               o_psel,
  output var  logic               o_penable,
  output var  logic               o_pwrite,
  output var  logic [7:0]         o_paddr,
  output var  tsr_pkg::tsr_word_t o_pwdata
);
  import tsr_pkg::*;
  initial {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata} = '0;
  // Request held until pready is sampled high, then released
  task automatic xfer(input logic w, input logic [7:0] a, input tsr_word_t d,
                      output tsr_word_t r, output logic e);
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    do @(posedge i_clk); while (i_pready !== 1'b1);
    r = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### test/tsr_recorder_chk.sv
// Port assertions of the signal recorder
`timescale 1ns/1ps
`default_nettype none
module tsr_recorder_chk (
  input wire logic               i_sys_clk,
  input wire logic               i_reset,
  input wire logic               i_psel,
  input wire logic               i_penable,
  input wire logic               i_pwrite,
  input wire logic [7:0]         i_paddr,
  input wire tsr_pkg::tsr_word_t i_pwdata,
  input wire tsr_pkg::tsr_word_t o_prdata,
  input wire logic               o_pready,
  input wire logic               o_pslverr,
  input wire logic               o_irq,
  input wire logic               o_recording,
  input wire logic               i_link_on,
  input wire logic [3:0]         i_ctrl_mode
);
  import tsr_pkg::*;
  logic [2:0] zero_h;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // Link on and mode without actual value for three cycles
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) zero_h <= '0;
    else zero_h <= {zero_h[1:0], i_link_on && !(i_ctrl_mode inside {4'h4, 4'h7, 4'h9})};
  end
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_rd(a);
    o_pready && !i_pwrite && i_paddr == a;
  endsequence
  AST_ANSWER: assert property (s_setup |=> o_pready) else $error("no answer");
  AST_PULSE: assert property (o_pready |=> !o_pready) else $error("long ready");
  AST_ERR: assert property (o_pslverr |-> o_pready) else $error("stray error");
  AST_UNMAP: assert property (o_pready && i_paddr > 8'h34 |-> o_pslverr && o_prdata == '0)
    else $error("unmapped ok");
  AST_MAP: assert property (o_pready && i_paddr <= 8'h34 && i_paddr[1:0] == 2'h0
    |-> !o_pslverr) else $error("mapped error");
  AST_CMD_RD: assert property (s_rd(8'h00) |-> o_prdata == '0) else $error("cmd reads");
  AST_ACT: assert property (s_rd(8'h2c) and zero_h == 3'h7 |-> o_prdata == '0)
    else $error("actual shown");
  AST_LINK: assert property (!i_link_on [*2] |-> !o_recording) else $error("rec link off");
  AST_IRQ: assert property (o_pready && i_pwrite && i_paddr == 8'h20 && i_pwdata == '0
    |-> ##2 !o_irq) else $error("irq masked");
endmodule
bind tsr_recorder tsr_recorder_chk tsr_recorder_chk_inst (
  .i_sys_clk   (i_sys_clk),
  .i_reset     (i_reset),
  .i_psel      (i_psel),
  .i_penable   (i_penable),
  .i_pwrite    (i_pwrite),
  .i_paddr     (i_paddr),
  .i_pwdata    (i_pwdata),
  .o_prdata    (o_prdata),
  .o_pready    (o_pready),
  .o_pslverr   (o_pslverr),
  .o_irq       (o_irq),
  .o_recording (o_recording),
  .i_link_on   (i_link_on),
  .i_ctrl_mode (i_ctrl_mode)
);
`default_nettype wire

// ### test/tb_top.sv
// Testbench of the triggered signal recorder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tsr_pkg::*;
  logic         i_sys_clk = 0, i_reset = 1, i_link_on = 1, i_win_reached = 0, i_trail_err = 0;
  logic [127:0] i_sig = {96'h0, 16'h1234, 16'h0050};
  logic [3:0]   i_ctrl_mode = 0;
  tsr_smp_t     i_act_val = 0, i_ctrl_diff = 0, i_sol_a_set = 0, i_sol_b_set = 0;
  logic [7:0]   i_din = 0, i_dout = 0, i_paddr, n;
  logic         i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_irq, o_recording, e;
  tsr_word_t    i_pwdata, o_prdata, rv;
  logic [3:0]   md [5] = '{4'h4, 4'h7, 4'h9, 4'h0, 4'h8};
  int           fail_count = 0, checked = 0, cyc = 0;
  tsr_host tsr_host_inst (.i_clk(i_sys_clk), .i_pready(o_pready), .i_pslverr(o_pslverr),
    .i_prdata(o_prdata), .o_psel(i_psel), .o_penable(i_penable), .o_pwrite(i_pwrite),
    .o_paddr(i_paddr), .o_pwdata(i_pwdata));
  tsr_recorder #(.TICK_CYC(4)) tsr_recorder_inst (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq), .o_recording(o_recording),
    .i_link_on(i_link_on), .i_sig(i_sig), .i_ctrl_mode(i_ctrl_mode), .i_act_val(i_act_val),
    .i_ctrl_diff(i_ctrl_diff), .i_sol_a_set(i_sol_a_set), .i_sol_b_set(i_sol_b_set),
    .i_win_reached(i_win_reached), .i_trail_err(i_trail_err), .i_din(i_din),
    .i_dout(i_dout));
  initial begin
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic check(input tsr_word_t got, input tsr_word_t exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a); tsr_host_inst.xfer(1'b0, a, '0, rv, e); endtask
  task automatic wr(input logic [7:0] a, input tsr_word_t d);
    tsr_host_inst.xfer(1'b1, a, d, rv, e);
  endtask
  task automatic sig0(input tsr_smp_t v);
    @(posedge i_sys_clk);
    i_sig[15:0] <= v;
  endtask
  task automatic wait_rec();
    for (int k = 0; k < 50 && o_recording !== 1'b1; k++) @(posedge i_sys_clk);
  endtask
  task automatic t_capture();
    wr(8'h04, 32'h3);
    wr(8'h08, 32'h8);
    wr(8'h0c, 32'h2);
    wr(8'h10, 32'h100);
    wr(8'h00, 32'h1);
    rd(8'h18);
    check(rv & 32'h3, 32'h1);
    sig0(16'h0200);
    wait_rec();
    repeat (42) @(posedge i_sys_clk);
    rd(8'h18);
    check(rv & 32'hff03, 32'h0602);
    rd(8'h24);
    check(rv, 32'h1234_0200);
    rd(8'h28);
    check(rv, 32'h0);
    wr(8'h00, 32'h2);
    sig0(16'h0050);
    rd(8'h18);
    check(rv & 32'h3, 32'h0);
    n = rv[15:8];
    wr(8'h00, 32'h1);
    sig0(16'h0200);
    wait_rec();
    repeat (12) @(posedge i_sys_clk);
    rd(8'h18);
    check(32'(rv[15:8] > n), 32'h1);
    wr(8'h04, 32'h43);
    rd(8'h18);
    check(rv & 32'hff03, 32'h0);
    wr(8'h00, 32'h1);
    sig0(16'h0050);
    wait_rec();
    check(32'(o_recording), 32'h1);
    wr(8'h00, 32'h4);
    rd(8'h18);
    check(rv & 32'hff03, 32'h0);
  endtask
  task automatic t_full();
    wr(8'h04, 32'hb);
    wr(8'h08, 32'h208);
    wr(8'h0c, 32'h0);
    rd(8'h0c);
    check(rv, 32'h1);
    wr(8'h0c, 32'd99999);
    rd(8'h0c);
    check(rv, 32'd15000);
    wr(8'h0c, 32'h1);
    wr(8'h20, 32'h2);
    wr(8'h00, 32'h1);
    sig0(16'h0200);
    for (int k = 0; k < 2000 && o_irq !== 1'b1; k++) @(posedge i_sys_clk);
    rd(8'h18);
    check(rv & 32'hff03, 32'hfa03);
    wr(8'h00, 32'h1);
    rd(8'h18);
    check(rv & 32'hff00, 32'hfa00);
    rd(8'h24);
    check(rv, 32'h1234_0200);
    rd(8'h28);
    check(rv, 32'h1234_0000);
    wr(8'h20, 32'h0);
    repeat (2) @(posedge i_sys_clk);
    check(32'(o_irq), 32'h0);
    wr(8'h20, 32'h2);
    repeat (2) @(posedge i_sys_clk);
    check(32'(o_irq), 32'h1);
    wr(8'h1c, 32'h2);
    repeat (2) @(posedge i_sys_clk);
    check(32'(o_irq), 32'h0);
  endtask
  task automatic t_link();
    wr(8'h00, 32'h4);
    @(posedge i_sys_clk) i_link_on <= 1'b0;
    wr(8'h00, 32'h1);
    sig0(16'h0050);
    sig0(16'h0200);
    rd(8'h18);
    check(rv & 32'h3, 32'h0);
    @(posedge i_sys_clk) i_link_on <= 1'b1;
    rd(8'h40);
    check(rv, 32'h0);
    check(32'(e), 32'h1);
  endtask
  task automatic t_readout();
    for (int k = 0; k < 5; k++) begin
      @(posedge i_sys_clk);
      i_ctrl_mode <= md[k];
      i_act_val   <= 16'h1000 + 16'(k);
      i_ctrl_diff <= 16'h2000 + 16'(k);
      i_sol_a_set <= 16'h3000 + 16'(k);
      i_sol_b_set <= 16'h4000 + 16'(k);
      {i_win_reached, i_trail_err, i_din, i_dout} <= {k[1:0], 8'h10 + 8'(k), 8'h81 - 8'(k)};
      repeat (2) @(posedge i_sys_clk);
      rd(8'h2c);
      check(rv, (md[k] inside {4'h4, 4'h7, 4'h9}) ? {i_ctrl_diff, i_act_val} : '0);
      rd(8'h30);
      check(rv, {i_sol_b_set, i_sol_a_set});
      rd(8'h34);
      check(rv, {14'h0, i_dout, i_din, i_trail_err, i_win_reached});
    end
  endtask
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    rd(8'h0c);
    check(rv, 32'h1);
    rd(8'h18);
    check(rv, 32'h0);
    t_capture();
    t_full();
    t_link();
    t_readout();
    conclude();
  end
endmodule
`default_nettype wire
